// [psrg_pkg.sv]
// package for the peripheral select and ready generator
package psrg_pkg;
	localparam logic [31:0] PBS_OFFSET     = 32'h0000_0290; // index A4 times four
	localparam logic [31:0] MPC_OFFSET     = 32'h0000_02A0; // index A8 times four
	localparam logic [31:0] UMC_OFFSET     = 32'h0000_0280; // index A0 times four
	localparam logic [7:0]  PBS_INDEX      = 8'hA4;
	localparam logic [7:0]  MPC_INDEX      = 8'hA8;
	localparam logic [7:0]  UMC_INDEX      = 8'hA0;
	localparam logic [15:0] UMC_RESET      = 16'hFFFB;
	localparam int          BASE_MSB       = 15;
	localparam int          BASE_LSB       = 6;
	localparam int          IO_CLR_MSB     = 15;
	localparam int          IO_CLR_LSB     = 12;
	localparam int          EXT_BIT        = 7;
	localparam int          SPACE_BIT      = 6;
	localparam int          RDY_IGN_BIT    = 2;
	localparam int          BLOCK_SHIFT    = 7;
	localparam int          NUM_SEL        = 7;
	localparam logic [6:0]  SEL_IDLE       = 7'h7F;

	typedef struct packed {
		logic        valid;
		logic        mem;
		logic        internal;
		logic [19:0] addr;
	} psrg_cycle_s;

	typedef struct packed {
		logic [6:0] sel_n;
		logic       upper_n;
		logic       ready;
	} psrg_sel_s;
endpackage

// [psrg_top.sv]
// peripheral chip select decoder with wait-state ready generator
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module psrg_top #(
	parameter int NUM_SEL = 7
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic [31:0]           wb_adr_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic      [31:0]           wb_dat_o,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic                  wb_we_i,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	output logic                       wb_ack_o,
	input  wire psrg_pkg::psrg_cycle_s cycle_i,
	input  wire logic                  async_ready_in_i,
	input  wire logic                  sync_ready_in_i,
	output psrg_pkg::psrg_sel_s        sel_o
);
	// registers
	logic [15:0] pbs_r, pbs_nxt;
	logic [15:0] mpc_r, mpc_nxt;
	logic [15:0] umc_r, umc_nxt;
	logic        pbs_seen_r, pbs_seen_nxt;
	logic        mpc_seen_r, mpc_seen_nxt;
	logic        ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	// pin synchronisers
	logic [1:0]  ard_r, srd_r;
	// cycle tracking
	logic [1:0]  wait_r, wait_nxt;
	logic        busy_r, busy_nxt;
	psrg_pkg::psrg_sel_s out_r, out_nxt;
	logic [1:0]  lat_a_r, lat_a_nxt;

	function automatic logic [2:0] rdy_field(input logic [15:0] v);
		rdy_field = v[2:0];
	endfunction

	// bus slave: one-cycle ack, unmapped reads return zero, writes ignored
	logic req, hit_pbs, hit_mpc, hit_umc;
	always_comb begin
		req     = wb_cyc_i && wb_stb_i && !ack_r;
		hit_pbs = wb_adr_i == psrg_pkg::PBS_OFFSET;
		hit_mpc = wb_adr_i == psrg_pkg::MPC_OFFSET;
		hit_umc = wb_adr_i == psrg_pkg::UMC_OFFSET;
	end

	always_comb begin
		pbs_nxt      = pbs_r;
		mpc_nxt      = mpc_r;
		umc_nxt      = umc_r;
		pbs_seen_nxt = pbs_seen_r;
		mpc_seen_nxt = mpc_seen_r;
		ack_nxt      = req;
		rdat_nxt     = rdat_r;
		if (req) begin
			rdat_nxt = 32'h0000_0000;
			if (hit_pbs) begin
				pbs_seen_nxt = 1'b1;
				rdat_nxt     = {16'h0000, pbs_r};
				if (wb_we_i) begin
					if (wb_sel_i[0])
						pbs_nxt[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1])
						pbs_nxt[15:8] = wb_dat_i[15:8];
				end
			end
			if (hit_mpc) begin
				mpc_seen_nxt = 1'b1;
				rdat_nxt     = {16'h0000, mpc_r};
				if (wb_we_i) begin
					if (wb_sel_i[0])
						mpc_nxt[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1])
						mpc_nxt[15:8] = wb_dat_i[15:8];
				end
			end
			if (hit_umc) begin
				rdat_nxt = {16'h0000, umc_r};
				if (wb_we_i) begin
					if (wb_sel_i[0])
						umc_nxt[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1])
						umc_nxt[15:8] = wb_dat_i[15:8];
				end
			end
		end
	end

	// decode of the current bus cycle
	logic [19:0] peripheral_base_address;
	logic [19:0] diff;
	logic        space_ok, in_pcs, in_ucs;
	logic [2:0]  blk;
	logic [2:0]  mode;
	logic        ext_ok;
	always_comb begin
		peripheral_base_address      = {pbs_r[psrg_pkg::BASE_MSB:psrg_pkg::BASE_LSB], 10'h000};
		diff     = cycle_i.addr - peripheral_base_address;
		// software keeps bits 12..15 zero in I/O space, so a 20-bit compare is exact
		space_ok = cycle_i.mem == mpc_r[psrg_pkg::SPACE_BIT];
		blk      = diff[psrg_pkg::BLOCK_SHIFT +: 3];
		in_pcs   = cycle_i.valid && !cycle_i.internal && pbs_seen_r && mpc_seen_r && space_ok
			&& cycle_i.addr >= peripheral_base_address && diff[19:10] == 10'h000
			&& blk < 3'(NUM_SEL);
		if (in_pcs && (blk == 3'h5 || blk == 3'h6) && !mpc_r[psrg_pkg::EXT_BIT])
			in_pcs = 1'b0;
		in_ucs   = cycle_i.valid && cycle_i.mem && !cycle_i.internal
			&& cycle_i.addr[19:4] >= {umc_r[15:6], 6'h00};
		if (in_pcs)
			mode = (blk < 3'h4) ? rdy_field(pbs_r) : rdy_field(mpc_r);
		else
			mode = rdy_field(umc_r);
		// the synced ready pins only; raw pins never reach logic
		ext_ok = ard_r[1] || srd_r[1];
	end

	// wait generator and select outputs held for the whole cycle
	always_comb begin
		busy_nxt  = busy_r;
		wait_nxt  = wait_r;
		out_nxt   = out_r;
		lat_a_nxt = lat_a_r;
		out_nxt.ready = 1'b0;
		if (!busy_r) begin
			out_nxt.sel_n   = psrg_pkg::SEL_IDLE;
			out_nxt.upper_n = 1'b1;
			if (cycle_i.valid) begin
				busy_nxt  = 1'b1;
				wait_nxt  = mode[1:0];
				lat_a_nxt = cycle_i.addr[2:1];
				if (in_pcs)
					out_nxt.sel_n[blk] = 1'b0;
				else if (in_ucs)
					out_nxt.upper_n = 1'b0;
				if (!mpc_r[psrg_pkg::EXT_BIT])
					out_nxt.sel_n[6:5] = {cycle_i.addr[2], cycle_i.addr[1]};
				if (!in_pcs && !in_ucs) begin
					wait_nxt = 2'h0;
				end
			end
		end else begin
			if (wait_r != 2'h0) begin
				wait_nxt = wait_r - 2'h1;
			end else if (cycle_i.internal || mode[psrg_pkg::RDY_IGN_BIT] || ext_ok) begin
				// ready ends the cycle once the wait count is done and external ready is seen, unless ignored or internal
				out_nxt.ready   = 1'b1;
				busy_nxt        = 1'b0;
				out_nxt.sel_n   = psrg_pkg::SEL_IDLE;
				out_nxt.upper_n = 1'b1;
				if (!mpc_r[psrg_pkg::EXT_BIT])
					out_nxt.sel_n[6:5] = {lat_a_r[1], lat_a_r[0]};
			end
		end
	end

	always_ff @(posedge clk_i) begin
		ard_r <= {ard_r[0], async_ready_in_i};
		srd_r <= {srd_r[0], sync_ready_in_i};
		if (rst_i) begin
			pbs_r      <= 16'h0000;
			mpc_r      <= 16'h0000;
			umc_r      <= psrg_pkg::UMC_RESET;
			pbs_seen_r <= 1'b0;
			mpc_seen_r <= 1'b0;
			ack_r      <= 1'b0;
			rdat_r     <= 32'h0000_0000;
			wait_r     <= 2'h0;
			busy_r     <= 1'b0;
			lat_a_r    <= 2'h0;
			out_r      <= '{sel_n: psrg_pkg::SEL_IDLE, upper_n: 1'b1, ready: 1'b0};
		end else begin
			pbs_r      <= pbs_nxt;
			mpc_r      <= mpc_nxt;
			umc_r      <= umc_nxt;
			pbs_seen_r <= pbs_seen_nxt;
			mpc_seen_r <= mpc_seen_nxt;
			ack_r      <= ack_nxt;
			rdat_r     <= rdat_nxt;
			wait_r     <= wait_nxt;
			busy_r     <= busy_nxt;
			lat_a_r    <= lat_a_nxt;
			out_r      <= out_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign sel_o    = out_r;
endmodule // psrg_top

// [psrg_chk.sv]
// bound checker for the peripheral select and ready generator
`timescale 1ns/1ns
module psrg_chk (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic [31:0]           wb_adr_i,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_ack_o,
	input wire psrg_pkg::psrg_cycle_s cycle_i,
	input wire psrg_pkg::psrg_sel_s   sel_o
);
	logic pb_r;
	logic mp_r;
	wire  lo = !(&sel_o.sel_n[4:0]);
	always_ff @(posedge clk_i) begin
		pb_r <= !rst_i && (pb_r || wb_ack_o && wb_adr_i == psrg_pkg::PBS_OFFSET);
		mp_r <= !rst_i && (mp_r || wb_ack_o && wb_adr_i == psrg_pkg::MPC_OFFSET);
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_reset_idle: assert property (disable iff (1'h0) rst_i |=> sel_o.sel_n == 7'h7F && sel_o.upper_n)
		else $error("select active in reset");
	a_sel_access: assert property (lo |-> pb_r && mp_r) else $error("select before setup");
	a_sel_cause: assert property ($fell(&sel_o.sel_n[4:0]) |-> $past(cycle_i.valid))
		else $error("select without cycle");
	a_sel_hold: assert property (lo && !sel_o.ready |=> $stable(sel_o.sel_n[4:0]) || sel_o.ready)
		else $error("select moved in cycle");
	a_sel_onehot: assert property ($onehot0(~sel_o.sel_n[4:0])) else $error("two selects");
	a_ready_pulse: assert property (sel_o.ready |-> &sel_o.sel_n[4:0] ##1 !sel_o.ready)
		else $error("ready not a pulse");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack timing");
	a_read_width: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0) else $error("upper data set");
	c_upper: cover property (!sel_o.upper_n);
	c_line: cover property ($fell(sel_o.sel_n[6]));
	c_ready: cover property (sel_o.ready);
endmodule // psrg_chk

bind psrg_top psrg_chk chk_u (.*);

// [psrg_periph.sv]
// model of an external device answering its select after a set delay
`timescale 1ns/1ns
module psrg_periph (
	input  wire logic       clk_i,
	input  wire logic [7:0] sel_n_i,
	input  wire logic [3:0] delay_i,
	output logic            rdy_o
);
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	// restart when idle so every access waits afresh
	always_comb cnt_nxt = (&sel_n_i) ? 4'h0 : cnt_r + 4'h1;
	always_ff @(posedge clk_i) cnt_r <= cnt_nxt;
	// an idle bus reads ready as pulled up unless the delay is F, so unselected cycles still end;
	// a delay of F stands for an absent device that never answers
	assign rdy_o = (delay_i != 4'hF) && ((&sel_n_i) || cnt_r >= delay_i);
endmodule // psrg_periph

// [test_peripheral_select_ready_gen.sv]
// self-checking bench for the peripheral select and ready generator
`timescale 1ns/1ns
module test_peripheral_select_ready_gen;
	logic                  clk_i, rst_i, wb_we, wb_cyc, wb_stb, rdy, wb_ack_o;
	logic [31:0]           wb_adr, wb_dat, wb_dat_o;
	logic [3:0]            pdly;
	logic [7:0]            s;
	logic [15:0]           q;
	int                    fails, total_checks, lat;
	psrg_pkg::psrg_cycle_s cyc;
	psrg_pkg::psrg_sel_s   sel_o;
	psrg_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_sel_i(4'h3), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_ack_o(wb_ack_o),
		.cycle_i(cyc), .async_ready_in_i(rdy), .sync_ready_in_i(1'h0), .sel_o(sel_o));
	psrg_periph per_u (.clk_i(clk_i), .sel_n_i({sel_o.sel_n, sel_o.upper_n}), .delay_i(pdly), .rdy_o(rdy));
	initial begin
		clk_i = 1'h0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic wb(input logic [31:0] a, input logic w, input logic [15:0] d);
		{wb_adr, wb_we, wb_dat, wb_cyc, wb_stb} <= {a, w, 16'h0, d, 2'h3};
		do @(posedge clk_i); while (!wb_ack_o);
		q = wb_dat_o[15:0];
		{wb_cyc, wb_stb} <= 2'h0;
		@(posedge clk_i);
	endtask
	// address and space stay on the bus until ready; lat counts edges to it
	task automatic run(input logic [19:0] a, input logic m, input logic it);
		cyc <= {1'h1, m, it, a};
		lat = 0;
		do begin
			@(posedge clk_i);
			lat++;
			if (lat == 1) cyc.valid <= 1'h0;
			if (lat == 2) s = {sel_o.sel_n, sel_o.upper_n};
		end while (!sel_o.ready);
	endtask
	task automatic t_reset;
		chk({sel_o.sel_n, sel_o.upper_n}, 8'hFF);
		wb(32'h280, 1'h0, 16'h0);
		chk(q, 16'hFFFB);
		wb(32'h2F0, 1'h0, 16'h0);
		chk(q, 16'h0);
		wb(32'h290, 1'h1, 16'h0004);
		run(20'h00006, 1'h0, 1'h0);
		chk(s, 8'hFF);
	endtask
	task automatic t_decode;
		wb(32'h2A0, 1'h1, 16'h00C4);
		wb(32'h290, 1'h1, 16'h12FC);
		for (int n = 0; n < 7; n++) begin
			run(20'h12C00 + 20'(n * 128 + 127), 1'h1, 1'h0);
			chk(s, {~(7'h1 << n), 1'h1});
			chk(lat, 3);
		end
		run(20'h12F80, 1'h1, 1'h0);
		chk(s, 8'hFF);
		run(20'h12BFF, 1'h1, 1'h0);
		chk(s, 8'hFF);
	endtask
	task automatic t_waits;
		for (int w = 0; w < 4; w++) begin
			wb(32'h290, 1'h1, 16'h12C4 + 16'(w));
			run(20'h12C00, 1'h1, 1'h0);
			chk(lat, 3 + w);
		end
		wb(32'h2A0, 1'h1, 16'h00C5);
		run(20'h12E00, 1'h1, 1'h0);
		chk(lat, 4);
	endtask
	task automatic t_overlap;
		wb(32'h290, 1'h1, 16'h12C3);
		pdly <= 4'h0;
		run(20'h12C00, 1'h1, 1'h0);
		chk(lat, 6);
		pdly <= 4'h9;
		run(20'h12C00, 1'h1, 1'h0);
		chk(lat > 6 && lat < 15, 1);
		// silent device: flush the ready synchroniser so only can end the cycle
		pdly <= 4'hF;
		repeat (3) @(posedge clk_i);
		run(20'h12C00, 1'h1, 1'h1);
		chk(lat, 3);
		pdly <= 4'h0;
	endtask
	task automatic t_space;
		wb(32'h2A0, 1'h1, 16'h0084);
		wb(32'h290, 1'h1, 16'h0304);
		run(20'h03000, 1'h1, 1'h0);
		chk(s, 8'hFF);
		run(20'h03000, 1'h0, 1'h0);
		chk(s, 8'hFD);
		wb(32'h2A0, 1'h1, 16'h0004);
		run(20'h03002, 1'h0, 1'h0);
		chk(s, 8'h7D);
		run(20'h03280, 1'h0, 1'h0);
		chk(s, 8'h3F);
	endtask
	task automatic t_upper;
		pdly <= 4'h0;
		run(20'hFFC06, 1'h1, 1'h0);
		chk(s, 8'hFE);
		chk(lat, 6);
		run(20'hFFBFF, 1'h1, 1'h0);
		chk(s, 8'hFF);
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		{wb_adr, wb_dat, wb_we, wb_cyc, wb_stb, cyc, pdly} = '0;
		rst_i = 1'h1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'h0;
		t_reset();
		t_decode();
		t_waits();
		t_overlap();
		t_space();
		t_upper();
		test_done();
	end
	initial begin
		#20000;
		fails++;
		test_done();
	end
endmodule // test_peripheral_select_ready_gen
